/* asc_pkg.sv */
// Purpose: Constants and types shared by the converter sequencing control
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: Offsets are the printed register addresses
package asc_pkg;

  localparam int asc_addr_w = 8;
  localparam int asc_data_w = 8;
  localparam int asc_chan_n = 12;

  localparam logic [7:0] asc_off_mode = 8'h_c4;
  localparam logic [7:0] asc_off_result = 8'h_c5;
  localparam logic [7:0] asc_off_start = 8'h_c6;

  localparam logic [7:0] asc_mode_reset = 8'h_30;
  localparam logic [7:0] asc_mode_fixed = 8'h_30;
  localparam logic [7:0] asc_start_fixed = 8'h_7f;
  localparam logic [7:0] asc_unmapped_value = 8'h_00;

  localparam int asc_bit_period_sel = 7;
  localparam int asc_bit_ext_start = 6;
  localparam int asc_bit_busy = 7;

  localparam logic [7:0] asc_period_slow = 8'h_3e;
  localparam logic [7:0] asc_period_fast = 8'h_1f;

  typedef enum logic [1:0] {
    asc_idle,
    asc_converting
  } asc_state_type;

  typedef logic [asc_chan_n-1:0] asc_chan_onehot_type;

endpackage : asc_pkg

/* asc_core_if.sv */
// Purpose: Handshake between the sequencer and the result holding register
// Assumes: One clock domain
// Notes: Sequencer drives take strobe, channel and sample data, holding register returns held data
interface asc_core_if;
  logic sample_take;
  logic [asc_pkg::asc_chan_n-1:0] chan_onehot;
  logic [asc_pkg::asc_data_w-1:0] sample_data;
  logic [asc_pkg::asc_data_w-1:0] held_data;

  modport seq (
    output sample_take,
    output chan_onehot,
    output sample_data,
    input held_data
  );
  modport hold (
    input sample_take,
    input sample_data,
    output held_data
  );
endinterface : asc_core_if

/* asc_result_hold.sv */
// Purpose: Result holding register for the converter
// Assumes: sample_take is a one-cycle pulse
// Notes: Holds no reset value; contents undefined until first conversion
module asc_result_hold (
  input wire logic clk,
  asc_core_if.hold core
);
  import asc_pkg::*;

  logic [asc_data_w-1:0] held;
  logic [asc_data_w-1:0] next_held;

  always_comb begin
    next_held = held;
    if (core.sample_take) begin
      next_held = core.sample_data;
    end
  end

  always_ff @(posedge clk) begin
    held <= next_held;
  end

  assign core.held_data = held;
endmodule : asc_result_hold

/* asc_adc_seq.sv */
// Purpose: Sequencing control for an 8-bit successive-approximation converter
// Assumes: Analog core delivers its sample on analog_data; trigger is a pin
// Notes: Register port with read data one cycle after the read strobe
//
// What this block does
// - Channel field 00xx selects nothing, 01xx inputs 0-3, 10xx 4-7, 11xx 8-11.
// - With the trigger enable clear the trigger pin is ignored.
// - With the trigger enable set either edge on the trigger pin starts.
// - Period select 0 gives 62 clocks, 1 gives 31 clocks per conversion.
// - The result register is 8-bit read only and undefined after reset.
// - The busy flag in bit 7 of the start register reads 1 while converting.
// - Writing 1 to the busy flag starts, writing 0 aborts a conversion.
module asc_adc_seq (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [asc_pkg::asc_addr_w-1:0] reg_addr,
  input wire logic [asc_pkg::asc_data_w-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [asc_pkg::asc_data_w-1:0] reg_rdata,
  input wire logic ext_start_pin,
  input wire logic [asc_pkg::asc_data_w-1:0] analog_data,
  output logic [asc_pkg::asc_chan_n-1:0] chan_onehot,
  output logic conv_active
);
  import asc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode

  function automatic asc_chan_onehot_type decode_chan(
    input logic [3:0] sel
  );
    asc_chan_onehot_type res;
    res = '0;
    if (sel[3:2] != 2'b00) begin
      res[{sel[3:2] - 2'b01, sel[1:0]}] = 1'b1;
    end
    return res;
  endfunction : decode_chan

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser and edge detect

  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic next_trig_meta;
  logic next_trig_sync;
  logic next_trig_prev;
  logic trig_edge;

  always_comb begin
    next_trig_meta = ext_start_pin;
    next_trig_sync = trig_meta;
    next_trig_prev = trig_sync;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= next_trig_meta;
      trig_sync <= next_trig_sync;
      trig_prev <= next_trig_prev;
    end
  end

  assign trig_edge = trig_sync ^ trig_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and conversion sequencer

  logic conv_period_sel;
  logic ext_start_enable;
  logic [3:0] chan_sel;
  asc_state_type state;
  logic [7:0] count;
  logic next_conv_period_sel;
  logic next_ext_start_enable;
  logic [3:0] next_chan_sel;
  asc_state_type next_state;
  logic [7:0] next_count;
  logic conv_busy_flag;
  logic wr_mode;
  logic wr_start;
  logic sw_start;
  logic sw_abort;
  logic hw_start;
  logic conv_done;

  asc_core_if core ();

  asc_result_hold asc_result_hold_i (
    .clk(clk),
    .core(core.hold)
  );

  assign conv_busy_flag = (state == asc_converting);
  assign wr_mode = reg_wr && (reg_addr == asc_off_mode);
  assign wr_start = reg_wr && (reg_addr == asc_off_start);
  assign sw_start = wr_start && reg_wdata[asc_bit_busy];
  assign sw_abort = wr_start && !reg_wdata[asc_bit_busy];
  assign hw_start = ext_start_enable && trig_edge;
  assign conv_done = conv_busy_flag && (count == 8'h_01) && !sw_abort;

  always_comb begin
    next_conv_period_sel = conv_period_sel;
    next_ext_start_enable = ext_start_enable;
    next_chan_sel = chan_sel;
    next_state = state;
    next_count = count;
    if (wr_mode) begin
      next_conv_period_sel = reg_wdata[asc_bit_period_sel];
      next_ext_start_enable = reg_wdata[asc_bit_ext_start];
      next_chan_sel = reg_wdata[3:0];
    end
    case (state)
      asc_idle: begin
        if (sw_start || hw_start) begin
          next_state = asc_converting;
          next_count = conv_period_sel ? asc_period_fast
                                       : asc_period_slow;
        end
      end
      asc_converting: begin
        if (sw_abort) begin
          next_state = asc_idle;
          next_count = '0;
        end else if (conv_done) begin
          next_state = asc_idle;
          next_count = '0;
        end else begin
          next_count = count - 8'h_01;
        end
      end
      default: begin
        next_state = asc_idle;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      conv_period_sel <= asc_mode_reset[asc_bit_period_sel];
      ext_start_enable <= asc_mode_reset[asc_bit_ext_start];
      chan_sel <= asc_mode_reset[3:0];
      state <= asc_idle;
      count <= '0;
    end else begin
      conv_period_sel <= next_conv_period_sel;
      ext_start_enable <= next_ext_start_enable;
      chan_sel <= next_chan_sel;
      state <= next_state;
      count <= next_count;
    end
  end

  assign core.sample_take = conv_done;
  assign core.sample_data = analog_data;
  assign core.chan_onehot = decode_chan(chan_sel);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and read port

  logic [asc_data_w-1:0] next_rdata;
  logic next_active;
  asc_chan_onehot_type next_onehot;

  always_comb begin
    next_rdata = reg_rdata;
    next_active = next_state == asc_converting;
    next_onehot = core.chan_onehot;
    if (reg_rd) begin
      case (reg_addr)
        asc_off_mode: next_rdata = asc_mode_fixed
          | {conv_period_sel, ext_start_enable, 2'b00, chan_sel};
        asc_off_result: next_rdata = core.held_data;
        asc_off_start: next_rdata = asc_start_fixed
          | {conv_busy_flag, 7'h_00};
        default: next_rdata = asc_unmapped_value;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
      conv_active <= 1'b0;
      chan_onehot <= '0;
    end else begin
      reg_rdata <= next_rdata;
      conv_active <= next_active;
      chan_onehot <= next_onehot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Cycle count of the running conversion, kept apart from the sequencer
  logic [7:0] run_len;
  logic run_fast;
  logic [7:0] next_run_len;
  logic next_run_fast;

  always_comb begin
    next_run_len = '0;
    next_run_fast = run_fast;
    if (state == asc_idle && next_state == asc_converting) begin
      next_run_fast = conv_period_sel;
    end
    if (next_state == asc_converting) begin
      next_run_len = run_len + 8'h_01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_len <= '0;
      run_fast <= 1'b0;
    end else begin
      run_len <= next_run_len;
      run_fast <= next_run_fast;
    end
  end

  a_slow_period_len: assert property (
    (conv_done && !run_fast) |-> (run_len == asc_period_slow))
    else $error("slow period length wrong");

  a_fast_period_len: assert property (
    (conv_done && run_fast) |-> (run_len == asc_period_fast))
    else $error("fast period length wrong");

  a_count_range: assert property (
    conv_busy_flag |-> (count >= 8'h_01 && count <= asc_period_slow))
    else $error("period counter out of range");

  a_trig_ignored: assert property (
    (state == asc_idle && !ext_start_enable && !sw_start)
    |=> state == asc_idle)
    else $error("start without request");

  a_trig_start: assert property (
    (state == asc_idle && hw_start) |=> conv_busy_flag)
    else $error("trigger edge did not start");

  a_abort_stops: assert property (
    (conv_busy_flag && sw_abort) |=> !conv_busy_flag)
    else $error("abort ignored");

  a_done_loads: assert property (
    conv_done |=> (!conv_busy_flag && core.held_data == $past(analog_data)))
    else $error("result not loaded at end");

  a_busy_read: assert property (
    (reg_rd && reg_addr == asc_off_start)
    |=> reg_rdata[asc_bit_busy] == $past(conv_busy_flag))
    else $error("busy flag read wrong");

  a_chan_none: assert property (
    (chan_sel[3:2] == 2'b00) |=> (chan_onehot == '0))
    else $error("channel selected while off");

  a_onehot_legal: assert property (
    $onehot0(chan_onehot))
    else $error("more than one channel selected");

  a_mode_chan: assert property (
    wr_mode |=> (chan_sel == $past(reg_wdata[3:0])))
    else $error("channel field not written");

  a_mode_read: assert property (
    (reg_rd && reg_addr == asc_off_mode) |=> reg_rdata[3:0] == $past(chan_sel))
    else $error("channel field read wrong");

  a_edge_needed: assert property (
    (state == asc_idle && !sw_start && !trig_edge) |=> state == asc_idle)
    else $error("start without a trigger edge");

  a_sw_start: assert property (
    (state == asc_idle && sw_start) |=> conv_busy_flag)
    else $error("start write did not start");

  a_busy_holds: assert property (
    (conv_busy_flag && !sw_abort && !conv_done) |=> conv_busy_flag)
    else $error("busy dropped early");

  a_active_mirror: assert property (
    conv_active == conv_busy_flag)
    else $error("active output differs from flag");

  c_sw_conv: cover property (sw_start ##[1:70] conv_done);
  c_hw_conv: cover property (hw_start ##[1:70] conv_done);
  c_abort: cover property (conv_busy_flag && sw_abort);
  c_fast_conv: cover property ((sw_start && conv_period_sel) ##[1:40] conv_done);
  c_edge_ignored: cover property (state == asc_idle && !ext_start_enable
    && trig_edge);

endmodule : asc_adc_seq

/* asc_core_model.sv */
// Purpose: Far-side model: analog core sample and trigger pin
// Assumes: One clock; the sample settles one cycle after a channel change
// Notes: Sample is 0x50 plus the input index, 0xee with no input selected
module asc_core_model (
  input wire logic clk,
  input wire logic [asc_pkg::asc_chan_n-1:0] chan_onehot,
  input wire logic trig_level,
  output logic [asc_pkg::asc_data_w-1:0] analog_data,
  output logic ext_start_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import asc_pkg::*;
  always_ff @(posedge clk) begin
    analog_data <= 8'h_ee;
    for (int i = 0; i < asc_chan_n; i++) begin
      if (chan_onehot[i]) begin
        analog_data <= 8'h_50 + 8'(i);
      end
    end
  end
  assign ext_start_pin = trig_level;
endmodule : asc_core_model

/* asc_adc_seq_tb.sv */
// Purpose: Self-checking bench for the converter sequencing control
// Assumes: 100 MHz clock, reset held low for six cycles
// Notes: Register tasks follow the one-cycle strobe port
module asc_adc_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asc_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, ext_start_pin, conv_active, trig_level;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, analog_data;
  logic [11:0] chan_onehot;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  asc_adc_seq asc_adc_seq_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_start_pin(ext_start_pin),
    .analog_data(analog_data), .chan_onehot(chan_onehot),
    .conv_active(conv_active));
  asc_core_model asc_core_model_i (.clk(clk), .chan_onehot(chan_onehot),
    .trig_level(trig_level), .analog_data(analog_data),
    .ext_start_pin(ext_start_pin));
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_count(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      bad_count++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_count
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_val({8'h_00, reg_rdata}, {8'h_00, exp});
  endtask : check_reg
  // Cycles from the start edge until busy drops
  task automatic conv_len(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (conv_active === 1'b1 && k < 200);
  endtask : conv_len
  // Cycles until busy rises, 10 when it never does
  task automatic wait_busy(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (conv_active !== 1'b1 && k < 10);
  endtask : wait_busy
  function automatic logic [11:0] exp_sel(input logic [3:0] s);
    if (s[3:2] == 2'b00) begin
      return 12'h_000;
    end
    return 12'h_001 << (int'(s[3:2]) * 4 - 4 + int'(s[1:0]));
  endfunction : exp_sel
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    reg_addr = 8'h_00;
    reg_wdata = 8'h_00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    trig_level = 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    check_reg(asc_off_mode, 8'h_30);
    check_reg(asc_off_start, 8'h_7f);
    check_reg(8'h_c0, 8'h_00);
    for (int s = 0; s < 16; s++) begin
      reg_write(asc_off_mode, 8'(s));
      repeat (3) @(posedge clk);
      #1;
      chk_val({4'h_0, chan_onehot}, {4'h_0, exp_sel(4'(s))});
      check_reg(asc_off_mode, 8'h_30 | 8'(s));
    end
    reg_write(asc_off_mode, 8'h_05);
    reg_write(asc_off_start, 8'h_80);
    conv_len(n);
    chk_count(n, 62);
    check_reg(asc_off_result, 8'h_51);
    check_reg(asc_off_start, 8'h_7f);
    reg_write(asc_off_mode, 8'h_8a);
    reg_write(asc_off_start, 8'h_80);
    conv_len(n);
    chk_count(n, 31);
    reg_write(asc_off_result, 8'h_00);
    check_reg(asc_off_result, 8'h_56);
    reg_write(asc_off_mode, 8'h_0c);
    reg_write(asc_off_start, 8'h_80);
    check_reg(asc_off_start, 8'h_ff);
    reg_write(asc_off_start, 8'h_00);
    conv_len(n);
    chk_count(n, 1);
    check_reg(asc_off_result, 8'h_56);
    @(posedge clk);
    trig_level <= 1'b1;
    wait_busy(n);
    chk_count(n, 10);
    reg_write(asc_off_mode, 8'h_4c);
    trig_level <= 1'b0;
    wait_busy(n);
    chk_count(int'(n < 8), 1);
    conv_len(n);
    check_reg(asc_off_result, 8'h_58);
    @(posedge clk);
    trig_level <= 1'b1;
    wait_busy(n);
    chk_count(int'(n < 8), 1);
    conv_len(n);
    reg_write(asc_off_start, 8'h_80);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    check_reg(asc_off_start, 8'h_7f);
    check_reg(asc_off_mode, 8'h_30);
    give_verdict();
  end
endmodule : asc_adc_seq_tb
